// ---- core/psx_pkg.sv ----
// Constants, opcodes and carrier types for the packed SIMD execution unit
package psx_pkg;

  // Queue and register file shape
  localparam int QUEUE_DEPTH = 4;
  localparam int QPTR_W = 2;
  localparam int NUM_PREGS = 8;
  localparam int PREG_W = 64;

  // Latencies in clocks, counted from the pop of the queue head
  localparam int GPR_MOVE_LAT = 5;

  // Tag word value meaning every stack entry is empty
  localparam logic [15:0] TAG_ALL_EMPTY = 16'hffff;

  // Register form marker in the operand byte
  localparam logic [1:0] MODE_REGREG = 2'h3;

  // Second opcode byte, following the 0f escape
  localparam logic [7:0] OP_EMPTY_STATE = 8'h77;
  localparam logic [7:0] OP_MOVE_DOUBLEWORD_LOAD = 8'h6e;
  localparam logic [7:0] OP_MOVE_DOUBLEWORD_STORE = 8'h7e;
  localparam logic [7:0] OP_MOVE_QUADWORD_LOAD = 8'h6f;
  localparam logic [7:0] OP_MOVE_QUADWORD_STORE = 8'h7f;
  localparam logic [7:0] OP_PACK_DW_SSAT = 8'h6b;
  localparam logic [7:0] OP_PACK_WB_SSAT = 8'h63;
  localparam logic [7:0] OP_ADD_B = 8'hfc;
  localparam logic [7:0] OP_ADD_W = 8'hfd;
  localparam logic [7:0] OP_ADD_D = 8'hfe;
  localparam logic [7:0] OP_ADD_SB = 8'hec;
  localparam logic [7:0] OP_ADD_SW = 8'hed;
  localparam logic [7:0] OP_ADD_UB = 8'hdc;
  localparam logic [7:0] OP_ADD_UW = 8'hdd;

  // Lane granularity
  typedef enum logic [1:0] {
    PSX_BYTE,
    PSX_WORD,
    PSX_DWORD,
    PSX_QWORD
  } psx_gran_t;

  // One decoded packed instruction as handed over by the integer unit
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] modrm;
    logic [63:0] memData;
    logic [31:0] gprData;
  } psx_instr_t;

  // Store toward memory or a packed register image
  typedef struct packed {
    logic valid;
    logic wide;
    logic [63:0] data;
  } psx_store_t;

  // Packed-to-general register move result
  typedef struct packed {
    logic valid;
    logic [2:0] index;
    logic [31:0] data;
  } psx_gpr_t;

endpackage

// ---- core/psx_issue_queue.sv ----
// Four-entry in-order queue of pending packed instructions
module psx_issue_queue (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Handoff from the integer unit
  input wire logic pushValid,
  input psx_pkg::psx_instr_t pushData,
  output logic pushReady,
  // Drain toward the execution stage
  output logic popValid,
  output psx_pkg::psx_instr_t popData,
  input wire logic popReady
);
  import psx_pkg::*;

  psx_instr_t slots_q [QUEUE_DEPTH];
  logic [QPTR_W-1:0] wrPtr_q;
  logic [QPTR_W-1:0] rdPtr_q;
  logic [QPTR_W:0] count_q;
  logic [QPTR_W:0] count_d;
  logic doPush;
  logic doPop;

  // Push only while ready, so a full queue never overwrites
  assign doPush = pushValid && pushReady;
  assign doPop = popValid && popReady;
  assign popValid = (count_q != '0);
  assign popData = slots_q[rdPtr_q];

  // Occupancy bookkeeping
  always_comb begin
    count_d = count_q;
    if (doPush && !doPop) begin
      count_d = count_q + 1'b1;
    end else if (doPop && !doPush) begin
      count_d = count_q - 1'b1;
    end
  end

  // Storage written at the tail, read at the head, so order is kept
  always_ff @(posedge clock) begin
    if (doPush) begin
      slots_q[wrPtr_q] <= pushData;
    end
  end

  // Pointers and count
  always_ff @(posedge clock) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (doPush) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (doPop) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
      count_q <= count_d;
    end
  end

  // Ready registered from next occupancy; stalls the integer unit when full
  always_ff @(posedge clock) begin
    if (rst) begin
      pushReady <= 1'b0;
    end else begin
      pushReady <= (count_d != (QPTR_W+1)'(QUEUE_DEPTH));
    end
  end

endmodule // psx_issue_queue

// ---- core/psx_exec_unit.sv ----
// Packed SIMD execution unit: queue, packed register file and lane datapath
module psx_exec_unit (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Instruction handoff from the integer unit
  input wire logic issueValid,
  input psx_pkg::psx_instr_t issueInstr,
  output logic issueReady,
  // Retirement, one pulse per instruction in issue order
  output logic retireValid_q,
  output logic [7:0] retireOpcode_q,
  output logic retireIllegal_q,
  // Store of a packed register toward memory
  output psx_pkg::psx_store_t store_q,
  // Packed register moved to a general register
  output psx_pkg::psx_gpr_t gprWrite_q,
  // Floating-point tag word update
  output logic tagWrite_q,
  output logic [15:0] tagWord_q
);
  import psx_pkg::*;

  // Clamp a lane value held in wide signed form to w bits
  function automatic logic [31:0] clampLane(input logic signed [33:0] v, input int w,
                                            input logic sgn);
    logic signed [33:0] hi;
    logic signed [33:0] lo;
    logic signed [33:0] c;
    hi = sgn ? ((34'sd1 <<< (w - 1)) - 34'sd1) : ((34'sd1 <<< w) - 34'sd1);
    lo = sgn ? -(34'sd1 <<< (w - 1)) : 34'sd0;
    c = v;
    if (v > hi) begin
      c = hi;
    end else if (v < lo) begin
      c = lo;
    end
    return c[31:0];
  endfunction

  // Widen a lane of w bits, signed or unsigned
  function automatic logic signed [33:0] widenLane(input logic [31:0] x, input int w,
                                                    input logic sgn);
    logic signed [33:0] r;
    r = 34'sd0;
    for (int i = 0; i < 32; i++) begin
      if (i < w) begin
        r[i] = x[i];
      end
    end
    // Top bit of the lane is the sign for signed variants
    if (sgn && x[w-1]) begin
      for (int i = 0; i < 34; i++) begin
        if (i >= w) begin
          r[i] = 1'b1;
        end
      end
    end
    return r;
  endfunction

  // One lane add; wrap keeps the low w bits, saturation clamps
  function automatic logic [31:0] laneAdd(input logic [31:0] a, input logic [31:0] b,
                                          input int w, input logic sat, input logic sgn);
    logic signed [33:0] s;
    logic [31:0] r;
    s = widenLane(a, w, sgn) + widenLane(b, w, sgn);
    r = sat ? clampLane(s, w, sgn) : s[31:0];
    return r;
  endfunction

  // Packed add over all lanes of the chosen granularity
  function automatic logic [63:0] packedAdd(input logic [63:0] a, input logic [63:0] b,
                                            input psx_gran_t g, input logic sat,
                                            input logic sgn);
    logic [63:0] r;
    r = '0;
    unique case (g)
      PSX_BYTE: begin
        for (int i = 0; i < 8; i++) begin
          r[i*8 +: 8] = 8'(laneAdd({24'h0, a[i*8 +: 8]}, {24'h0, b[i*8 +: 8]}, 8, sat,
                                   sgn));
        end
      end
      PSX_WORD: begin
        for (int i = 0; i < 4; i++) begin
          r[i*16 +: 16] = 16'(laneAdd({16'h0, a[i*16 +: 16]}, {16'h0, b[i*16 +: 16]}, 16,
                                      sat, sgn));
        end
      end
      PSX_DWORD: begin
        for (int i = 0; i < 2; i++) begin
          r[i*32 +: 32] = laneAdd(a[i*32 +: 32], b[i*32 +: 32], 32, sat, sgn);
        end
      end
      PSX_QWORD: begin
        r = a + b;
      end
    endcase
    return r;
  endfunction

  // Dword to word pack, signed saturation; destination fills the low half
  function automatic logic [63:0] packDwToW(input logic [63:0] dst, input logic [63:0] src);
    logic [63:0] r;
    r[15:0] = 16'(clampLane(widenLane(dst[31:0], 32, 1'b1), 16, 1'b1));
    r[31:16] = 16'(clampLane(widenLane(dst[63:32], 32, 1'b1), 16, 1'b1));
    r[47:32] = 16'(clampLane(widenLane(src[31:0], 32, 1'b1), 16, 1'b1));
    r[63:48] = 16'(clampLane(widenLane(src[63:32], 32, 1'b1), 16, 1'b1));
    return r;
  endfunction

  // Word to byte pack, signed saturation; destination fills the low half
  function automatic logic [63:0] packWToB(input logic [63:0] dst, input logic [63:0] src);
    logic [63:0] r;
    r = '0;
    for (int i = 0; i < 4; i++) begin
      r[i*8 +: 8] = 8'(clampLane(widenLane({16'h0, dst[i*16 +: 16]}, 16, 1'b1), 8,
                                 1'b1));
      r[32+i*8 +: 8] = 8'(clampLane(widenLane({16'h0, src[i*16 +: 16]}, 16, 1'b1), 8,
                                    1'b1));
    end
    return r;
  endfunction

  // Queue head
  logic headValid;
  psx_instr_t head;

  // Packed register file in flip-flops
  logic [PREG_W-1:0] pregs_q [NUM_PREGS];

  // Decode of the head instruction
  logic regForm;
  logic [2:0] fieldReg;
  logic [2:0] fieldRm;
  logic [63:0] destVal;
  logic [63:0] srcVal;

  // Results of the current instruction
  logic wrEn;
  logic [2:0] wrIdx;
  logic [63:0] wrData;
  logic illegal;
  logic storeEn;
  logic storeWide;
  logic [63:0] storeData;
  logic gprEn;
  logic tagEn;

  // Delay line carrying the packed-to-general move to its fifth clock
  psx_gpr_t gprPipe_q [GPR_MOVE_LAT-1];

  // Queue between the integer unit and execution; always drained one per clock
  // Pop is tied ready: every opcode here issues in one clock, so the head never waits
  // Limitation: with this drain the queue only fills if a slower opcode is added later
  psx_issue_queue queue (
    .clock(clock),
    .rst(rst),
    .pushValid(issueValid),
    .pushData(issueInstr),
    .pushReady(issueReady),
    .popValid(headValid),
    .popData(head),
    .popReady(1'b1)
  );

  // Operand byte fields; top bits 11 means register to register
  assign regForm = (head.modrm[7:6] == MODE_REGREG);
  assign fieldReg = head.modrm[5:3];
  assign fieldRm = head.modrm[2:0];
  assign destVal = pregs_q[fieldReg];
  assign srcVal = regForm ? pregs_q[fieldRm] : head.memData;

  // Execution decode; every instruction here completes in one clock except the register-form doubleword store, which takes five
  always_comb begin
    wrEn = 1'b0;
    wrIdx = fieldReg;
    wrData = '0;
    illegal = 1'b0;
    storeEn = 1'b0;
    storeWide = 1'b0;
    storeData = '0;
    gprEn = 1'b0;
    tagEn = 1'b0;
    unique case (head.opcode)
      OP_EMPTY_STATE: begin
        tagEn = 1'b1;
      end
      OP_MOVE_DOUBLEWORD_LOAD: begin
        wrEn = 1'b1;
        // Register form takes the general register, else memory; zero-extended
        wrData = regForm ? {32'h0, head.gprData} : {32'h0, head.memData[31:0]};
      end
      OP_MOVE_DOUBLEWORD_STORE: begin
        if (regForm) begin
          gprEn = 1'b1;
        end else begin
          storeEn = 1'b1;
          storeData = {32'h0, destVal[31:0]};
        end
      end
      OP_MOVE_QUADWORD_LOAD: begin
        wrEn = 1'b1;
        wrData = srcVal;
      end
      OP_MOVE_QUADWORD_STORE: begin
        if (regForm) begin
          wrEn = 1'b1;
          wrIdx = fieldRm;
          wrData = destVal;
        end else begin
          storeEn = 1'b1;
          storeWide = 1'b1;
          storeData = destVal;
        end
      end
      OP_PACK_DW_SSAT: begin
        wrEn = 1'b1;
        wrData = packDwToW(destVal, srcVal);
      end
      OP_PACK_WB_SSAT: begin
        wrEn = 1'b1;
        wrData = packWToB(destVal, srcVal);
      end
      OP_ADD_B: begin
        wrEn = 1'b1;
        wrData = packedAdd(destVal, srcVal, PSX_BYTE, 1'b0, 1'b0);
      end
      OP_ADD_W: begin
        wrEn = 1'b1;
        wrData = packedAdd(destVal, srcVal, PSX_WORD, 1'b0, 1'b0);
      end
      OP_ADD_D: begin
        wrEn = 1'b1;
        wrData = packedAdd(destVal, srcVal, PSX_DWORD, 1'b0, 1'b1);
      end
      OP_ADD_SB: begin
        wrEn = 1'b1;
        wrData = packedAdd(destVal, srcVal, PSX_BYTE, 1'b1, 1'b1);
      end
      OP_ADD_SW: begin
        wrEn = 1'b1;
        wrData = packedAdd(destVal, srcVal, PSX_WORD, 1'b1, 1'b1);
      end
      OP_ADD_UB: begin
        wrEn = 1'b1;
        wrData = packedAdd(destVal, srcVal, PSX_BYTE, 1'b1, 1'b0);
      end
      OP_ADD_UW: begin
        wrEn = 1'b1;
        wrData = packedAdd(destVal, srcVal, PSX_WORD, 1'b1, 1'b0);
      end
      default: begin
        // Unknown opcodes retire flagged and change nothing
        // An empty head decodes a stale slot instead; headValid masks every valid, write and retire output, but not the store and move payloads
        illegal = 1'b1;
      end
    endcase
  end

  // Register file write; a back-to-back reader sees the new value next clock
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < NUM_PREGS; i++) begin
        pregs_q[i] <= '0;
      end
    end else if (headValid && wrEn) begin
      pregs_q[wrIdx] <= wrData;
    end
  end

  // Retirement in queue order, one clock after leaving the queue
  always_ff @(posedge clock) begin
    if (rst) begin
      retireValid_q <= 1'b0;
      retireOpcode_q <= '0;
      retireIllegal_q <= 1'b0;
    end else begin
      retireValid_q <= headValid;
      retireOpcode_q <= headValid ? head.opcode : 8'h00;
      retireIllegal_q <= headValid && illegal;
    end
  end

  // Memory store results
  always_ff @(posedge clock) begin
    if (rst) begin
      store_q <= '0;
    end else begin
      store_q.valid <= headValid && storeEn;
      store_q.wide <= storeWide;
      store_q.data <= storeData;
    end
  end

  // Tag word empty marking, one clock latency
  always_ff @(posedge clock) begin
    if (rst) begin
      tagWrite_q <= 1'b0;
      tagWord_q <= '0;
    end else begin
      tagWrite_q <= headValid && tagEn;
      tagWord_q <= TAG_ALL_EMPTY;
    end
  end

  // Pipelined general register move: longer latency, yet one per clock
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < GPR_MOVE_LAT - 1; i++) begin
        gprPipe_q[i] <= '0;
      end
      gprWrite_q <= '0;
    end else begin
      gprPipe_q[0].valid <= headValid && gprEn;
      gprPipe_q[0].index <= fieldRm;
      gprPipe_q[0].data <= destVal[31:0];
      for (int i = 1; i < GPR_MOVE_LAT - 1; i++) begin
        gprPipe_q[i] <= gprPipe_q[i-1];
      end
      gprWrite_q <= gprPipe_q[GPR_MOVE_LAT-2];
    end
  end

endmodule // psx_exec_unit

// ---- tb/psx_exec_monitor.sv ----
// Checker of handoff, retire count and side outputs of the packed unit
module psx_exec_monitor (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Handoff
  input wire logic issueValid,
  input wire psx_pkg::psx_instr_t issueInstr,
  input wire logic issueReady,
  // Results
  input wire logic retireValid_q,
  input wire logic [7:0] retireOpcode_q,
  input wire logic retireIllegal_q,
  input wire psx_pkg::psx_store_t store_q,
  input wire psx_pkg::psx_gpr_t gprWrite_q,
  input wire logic tagWrite_q,
  input wire logic [15:0] tagWord_q
);
  timeunit 1ns;
  timeprecision 1ps;
  import psx_pkg::*;

  logic [3:0] pending_q;

  // Taken but not yet retired; catches lost or invented retires
  always_ff @(posedge clock) begin
    if (rst) begin
      pending_q <= 4'h0;
    end else begin
      pending_q <= pending_q + 4'(issueValid && issueReady) - 4'(retireValid_q);
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  ready_after_reset_a: assert property ($fell(rst) |-> !issueReady ##1 issueReady)
    else $error("handoff ready not raised one cycle after reset");
  issue_retires_a: assert property (issueValid && issueReady |-> ##[2:6] retireValid_q)
    else $error("taken instruction did not retire in time");
  retire_backed_a: assert property (retireValid_q |-> pending_q != 4'h0)
    else $error("retire without outstanding instruction");
  pending_bound_a: assert property (pending_q <= 4'(QUEUE_DEPTH + 1))
    else $error("more instructions held than the queue allows");
  idle_quiet_a: assert property (!retireValid_q |->
      retireOpcode_q == 8'h00 && !retireIllegal_q && !store_q.valid && !tagWrite_q)
    else $error("result outputs active without a retire");
  tag_pulse_a: assert property (tagWrite_q |-> retireOpcode_q == OP_EMPTY_STATE)
    else $error("tag write from wrong opcode");
  tag_value_a: assert property (!$past(rst) |-> tagWord_q == TAG_ALL_EMPTY)
    else $error("tag word not all empty");
  store_kind_a: assert property (store_q.valid |->
      (retireOpcode_q == OP_MOVE_QUADWORD_STORE && store_q.wide) ||
      (retireOpcode_q == OP_MOVE_DOUBLEWORD_STORE && !store_q.wide && store_q.data[63:32] == 32'h0))
    else $error("store shape does not match opcode");
  gpr_delay_a: assert property (gprWrite_q.valid |-> $past(retireOpcode_q, 4) == OP_MOVE_DOUBLEWORD_STORE)
    else $error("general register move not five clocks after execution");

  // Main scenarios reached
  tag_seen_c: cover property (tagWrite_q);
  gpr_seen_c: cover property (gprWrite_q.valid);
  illegal_seen_c: cover property (retireIllegal_q);
endmodule // psx_exec_monitor

bind psx_exec_unit psx_exec_monitor i_psx_exec_monitor (
  .clock(clock), .rst(rst), .issueValid(issueValid), .issueInstr(issueInstr),
  .issueReady(issueReady), .retireValid_q(retireValid_q), .retireOpcode_q(retireOpcode_q),
  .retireIllegal_q(retireIllegal_q), .store_q(store_q), .gprWrite_q(gprWrite_q),
  .tagWrite_q(tagWrite_q), .tagWord_q(tagWord_q)
);

// ---- tb/psx_int_model.sv ----
// Behavioural integer unit handing packed instructions over
module psx_int_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Handoff toward the packed unit
  output psx_pkg::psx_instr_t issueInstr,
  output logic issueValid,
  input wire logic issueReady
);
  timeunit 1ns;
  timeprecision 1ps;
  import psx_pkg::*;

  // Idle at time zero
  initial begin
    issueValid = 1'b0;
    issueInstr = '0;
  end

  // Offer one instruction and hold it until the edge that takes it
  task automatic issue(input psx_instr_t instr);
    while (rst) @(posedge clock);
    issueValid <= 1'b1;
    issueInstr <= instr;
    do begin
      @(posedge clock);
    end while (issueReady !== 1'b1);
  endtask

  // Withdraw; payload scrambled so a stale value is never taken by luck
  task automatic idle();
    issueValid <= 1'b0;
    issueInstr <= ~issueInstr;
  endtask
endmodule // psx_int_model

// ---- tb/tb_top.sv ----
// Self-checking bench for the packed SIMD execution unit
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import psx_pkg::*;

  typedef struct packed {
    logic [7:0] op;
    logic [63:0] a;
    logic [63:0] b;
    logic [63:0] res;
  } psx_row_t;

  localparam logic [63:0] VA = 64'h7fff_8000_00ff_0180;
  localparam logic [63:0] VB = 64'h0001_ffff_0001_ff80;

  // Lane ops: dest reg1 = a, source b, expected dest after
  psx_row_t rows [10] = '{
    '{OP_ADD_B, VA, VB, 64'h7f00_7fff_0000_0000},
    '{OP_ADD_W, VA, VB, 64'h8000_7fff_0100_0100},
    '{OP_ADD_D, VA, VB, 64'h8001_7fff_0101_0100},
    '{OP_ADD_SB, VA, VB, 64'h7f00_80ff_0000_0080},
    '{OP_ADD_SW, VA, VB, 64'h7fff_8000_0100_0100},
    '{OP_ADD_UB, VA, VB, 64'h7fff_ffff_00ff_ffff},
    '{OP_ADD_UW, VA, VB, 64'h8000_ffff_0100_ffff},
    '{OP_PACK_DW_SSAT, 64'hffff_8000_0000_7fff, 64'h8000_0000_ffff_fffe, 64'h8000_fffe_8000_7fff},
    '{OP_PACK_WB_SSAT, 64'hff80_0080_007f_fff0, 64'h8000_0001_ff7f_0100, 64'h8001_807f_807f_7ff0},
    '{OP_MOVE_QUADWORD_LOAD, VA, VB, VB}
  };

  logic clock = 1'b0;
  logic rst = 1'b1;
  logic issueValid, issueReady, retireValid_q, retireIllegal_q, tagWrite_q;
  logic [7:0] retireOpcode_q;
  logic [15:0] tagWord_q;
  psx_instr_t issueInstr;
  psx_store_t store_q;
  psx_gpr_t gprWrite_q;
  logic [64:0] stores [$];
  logic [34:0] gprs [$];
  logic [8:0] expRetire [$];
  int failCount = 0;
  int nChecks = 0;
  int cycles = 0;
  int tagSeen = 0;

  // Clock, 100 MHz
  always #5 clock = ~clock;

  psx_int_model i_psx_int_model (.clock(clock), .rst(rst), .issueInstr(issueInstr),
    .issueValid(issueValid), .issueReady(issueReady));

  psx_exec_unit i_psx_exec_unit (.clock(clock), .rst(rst), .issueValid(issueValid),
    .issueInstr(issueInstr), .issueReady(issueReady), .retireValid_q(retireValid_q),
    .retireOpcode_q(retireOpcode_q), .retireIllegal_q(retireIllegal_q), .store_q(store_q),
    .gprWrite_q(gprWrite_q), .tagWrite_q(tagWrite_q), .tagWord_q(tagWord_q));

  task automatic check(input string what, input logic [64:0] seen, input logic [64:0] exp);
    nChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Opcode 01 is unknown and must retire flagged
  task automatic send(input logic [7:0] op, input logic [7:0] mrm, input logic [63:0] mem,
    input logic [31:0] gpr);
    expRetire.push_back({op == 8'h01, op});
    i_psx_int_model.issue('{op, mrm, mem, gpr});
  endtask

  // Bounded wait for the next store, then compare {wide, data}
  task automatic expect_store(input string what, input logic [64:0] exp);
    int n;
    i_psx_int_model.idle();
    n = 0;
    // Always let an edge pass, so back-to-back calls never drive twice in one step
    do begin
      @(posedge clock);
      n++;
    end while (stores.size() == 0 && n < 20);
    check(what, stores.size() ? stores.pop_front() : 65'hx, exp);
  endtask

  // Results gathered in issue order; retire order checked as it happens
  always @(posedge clock) begin
    cycles++;
    if (store_q.valid === 1'b1) stores.push_back({store_q.wide, store_q.data});
    if (gprWrite_q.valid === 1'b1) gprs.push_back({gprWrite_q.index, gprWrite_q.data});
    if (tagWrite_q === 1'b1) tagSeen++;
    if (retireValid_q === 1'b1) begin
      check("retire", {retireIllegal_q, retireOpcode_q},
            expRetire.size() ? expRetire.pop_front() : 9'hx);
    end
    if (cycles == 5000) begin
      failCount++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    // Even rows register form (decoy memory data), odd rows memory form
    for (int i = 0; i < 10; i++) begin
      send(OP_MOVE_QUADWORD_LOAD, 8'h08, rows[i].a, 32'h0);
      send(OP_MOVE_QUADWORD_LOAD, 8'h10, rows[i].b, 32'h0);
      send(rows[i].op, i[0] ? 8'h08 : 8'hca, i[0] ? rows[i].b : ~rows[i].b, 32'h0);
      send(OP_MOVE_QUADWORD_STORE, 8'h08, 64'h0, 32'h0);
      expect_store("lane op", {1'b1, rows[i].res});
    end
    // Doubleword moves, both directions and forms
    send(OP_MOVE_DOUBLEWORD_LOAD, 8'hd8, 64'hffff_ffff_ffff_ffff, 32'h89ab_cdef);
    send(OP_MOVE_QUADWORD_STORE, 8'h18, 64'h0, 32'h0);
    send(OP_MOVE_DOUBLEWORD_STORE, 8'h18, 64'h0, 32'h0);
    send(OP_MOVE_DOUBLEWORD_STORE, 8'hdd, 64'h0, 32'h0);
    send(OP_MOVE_DOUBLEWORD_LOAD, 8'h20, 64'h1234_5678_9abc_def0, 32'h0);
    send(OP_MOVE_QUADWORD_STORE, 8'h20, 64'h0, 32'h0);
    expect_store("move_doubleword reg load", {1'b1, 64'h89ab_cdef});
    expect_store("move_doubleword store", {1'b0, 64'h89ab_cdef});
    expect_store("move_doubleword mem load", {1'b1, 64'h9abc_def0});
    repeat (8) @(posedge clock);
    check("gpr move", gprs.size() ? gprs.pop_front() : 35'hx, {3'h5, 32'h89ab_cdef});
    // Register-form quadword store, then empty state and an unknown opcode
    send(OP_MOVE_QUADWORD_STORE, 8'hd9, 64'h0, 32'h0);
    send(OP_MOVE_QUADWORD_STORE, 8'h08, 64'h0, 32'h0);
    // Register-form quadword load with decoy memory data
    send(OP_MOVE_QUADWORD_LOAD, 8'he3, 64'hffff_ffff_ffff_ffff, 32'h0);
    send(OP_MOVE_QUADWORD_STORE, 8'h20, 64'h0, 32'h0);
    send(OP_EMPTY_STATE, 8'h00, 64'h0, 32'h0);
    send(8'h01, 8'h08, 64'h0, 32'h0);
    expect_store("move_quadword reg store", {1'b1, 64'h89ab_cdef});
    expect_store("move_quadword reg load", {1'b1, 64'h89ab_cdef});
    repeat (8) @(posedge clock);
    check("tag pulses", 65'(tagSeen), 65'h1);
    check("drained", 65'(expRetire.size()), 65'h0);
    // Mid-run reset clears ready, tag word and packed registers
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    // Look between edges, release on an edge
    @(negedge clock);
    check("reset outputs", {issueReady, tagWord_q}, 65'h0);
    @(posedge clock);
    rst <= 1'b0;
    send(OP_MOVE_QUADWORD_STORE, 8'h08, 64'h0, 32'h0);
    expect_store("reg after reset", {1'b1, 64'h0});
    repeat (4) @(posedge clock);
    tally_and_finish();
  end
endmodule // tb_top
